// File: src/ocm_proc.sv
// Message processor end: buffers outgoing messages, drives both link clocks
// and collects received messages.
// Assumes the convergence end samples link pins through two flops.
`include "ocm_map.svh"

module ocm_fifo #(
  parameter int WIDTH = `OCM_FIFO_WIDTH,
  parameter int DEPTH = `OCM_FIFO_DEPTH
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ocm_fifo_st_t;

  ocm_fifo_st_t     q;
  ocm_fifo_st_t     d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (q.wp - q.rp) != (AW + 1)'(DEPTH);
  assign out_valid_out = q.wp != q.rp;
  assign out_data_out  = mem[q.rp[AW-1:0]];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + (AW + 1)'(1);
    end
    if (pop) begin
      d.rp = q.rp + (AW + 1)'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[q.wp[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : ocm_fifo

module ocm_proc (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  ocm_link_if.proc         link,
  input  wire logic        msg_tx_valid_in,
  input  wire logic [15:0] msg_tx_data_in,
  output logic             msg_tx_ready_out,
  output logic             msg_rx_valid_out,
  output logic [15:0]      msg_rx_data_out
);
  localparam logic [2:0] HALF_M1 = 3'(`OCM_HALF_CYC - 1);

  ocm_pkg::ocm_proc_st_t q;
  ocm_pkg::ocm_proc_st_t d;
  logic                  f_vld;
  logic [15:0]           f_dat;
  logic                  f_pop;

  // ----------------------------------------------------------------------------
  // Outgoing buffer; queued messages wait here, the convergence end holds one more in tbuf
  // ----------------------------------------------------------------------------
  ocm_fifo #(.WIDTH(`OCM_FIFO_WIDTH), .DEPTH(`OCM_FIFO_DEPTH)) u_fifo (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .in_valid_in  (msg_tx_valid_in),
    .in_data_in   (msg_tx_data_in),
    .in_ready_out (msg_tx_ready_out),
    .out_valid_out(f_vld),
    .out_data_out (f_dat),
    .out_ready_in (f_pop)
  );

  assign f_pop = (q.teng == ocm_pkg::OCM_IDLE) & f_vld & q.perm_s;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    d        = q;
    d.perm_m = link.tx_permit;
    d.perm_s = q.perm_m;
    d.rvld_m = link.rx_valid;
    d.rvld_s = q.rvld_m;
    d.rdat_m = link.rx_data;
    d.rdat_s = q.rdat_m;
    d.ovld   = 1'b0;

    // Transmit engine: data changes on falling edge, device samples on rise
    case (q.teng)
      ocm_pkg::OCM_IDLE: begin
        if (f_pop) begin
          d.tsh  = f_dat;
          d.tcnt = `OCM_MSG_BITS;
          d.tdiv = 3'h0;
          d.teng = ocm_pkg::OCM_RUN;
        end
      end
      ocm_pkg::OCM_RUN: begin
        d.tdiv = q.tdiv + 3'h1;
        if (q.tdiv == HALF_M1) begin
          d.tdiv = 3'h0;
          d.tclk = ~q.tclk;
          if (q.tclk) begin
            d.tsh  = {q.tsh[14:0], 1'b0};
            d.tcnt = q.tcnt - 5'h01;
            if (q.tcnt == 5'h01) begin
              d.tgap = `OCM_GAP_CYC;
              d.teng = ocm_pkg::OCM_GAP;
            end
          end
        end
      end
      ocm_pkg::OCM_GAP: begin
        // Wait until the permit seen here reflects the captured message
        d.tgap = q.tgap - 4'h1;
        if (q.tgap == 4'h1) begin
          d.teng = ocm_pkg::OCM_IDLE;
        end
      end
      default: begin
        d.teng = ocm_pkg::OCM_IDLE;
      end
    endcase

    // Receive engine: sample at end of high phase, device shifts after fall
    case (q.reng)
      ocm_pkg::OCM_IDLE: begin
        if (q.rvld_s) begin
          d.rcnt = `OCM_MSG_BITS;
          d.rdiv = 3'h0;
          d.reng = ocm_pkg::OCM_RUN;
        end
      end
      ocm_pkg::OCM_RUN: begin
        d.rdiv = q.rdiv + 3'h1;
        if (q.rdiv == HALF_M1) begin
          d.rdiv = 3'h0;
          d.rclk = ~q.rclk;
          if (q.rclk) begin
            d.rsh  = {q.rsh[14:0], q.rdat_s};
            d.rcnt = q.rcnt - 5'h01;
            if (q.rcnt == 5'h01) begin
              d.ovld = 1'b1;
              d.odat = {q.rsh[14:0], q.rdat_s};
              d.rgap = `OCM_GAP_CYC;
              d.reng = ocm_pkg::OCM_GAP;
            end
          end
        end
      end
      ocm_pkg::OCM_GAP: begin
        d.rgap = q.rgap - 4'h1;
        if (q.rgap == 4'h1) begin
          d.reng = ocm_pkg::OCM_IDLE;
        end
      end
      default: begin
        d.reng = ocm_pkg::OCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q      <= '0;
      q.teng <= ocm_pkg::OCM_IDLE;
      q.reng <= ocm_pkg::OCM_IDLE;
    end else begin
      q <= d;
    end
  end

  assign link.tx_clk      = q.tclk;
  assign link.tx_data     = q.tsh[15];
  assign link.rx_clk      = q.rclk;
  assign msg_rx_valid_out = q.ovld;
  assign msg_rx_data_out  = q.odat;

endmodule : ocm_proc

// File: src/ocm_map.svh
// Constants for the overhead channel message convergence block.
// Assumes both ends run on mclk_in at 20 MHz and the message link clocks are
// made by the processor end.
//
// Summary of operation
// - Two opposite two-octet message streams, independent rates.
// - Serial octets go most significant bit first.
// - Processor end drives transmit and receive clocks.
// - Transmit permit only while outgoing opcode idle.
// - Receive valid only while received opcode idle.
// - Processor end does all message buffering; the convergence end still holds one outgoing message in tbuf.
// - Line-control message wins over management message.
// - No line-control message means opcode 0xFF.
// - Idle opcode carries next message or 0x0000.
// - Line-control suspends messages, opcode not 0xFF.
// - After line-control sent, opcode returns idle.
// - Idle received opcode sends data octets upward.
// - Processor picks valid words using receive valid.
// - Non-idle received field goes to line control.
// - Same behaviour downstream and upstream.
`ifndef OCM_MAP_SVH
`define OCM_MAP_SVH

// ----------------------------------------------------------------------------
// Field values
// ----------------------------------------------------------------------------
`define OCM_IDLE_OP      8'hFF
`define OCM_NULL_DATA    16'h0000
`define OCM_MSG_BITS     5'h10

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OCM_MCLK_NS      50
`define OCM_LINK_NS      400
`define OCM_HALF_CYC     ((`OCM_LINK_NS / `OCM_MCLK_NS) / 2)
`define OCM_GAP_CYC      4'h8

// ----------------------------------------------------------------------------
// Processor-side buffer
// ----------------------------------------------------------------------------
`define OCM_FIFO_DEPTH   32
`define OCM_FIFO_WIDTH   16

`endif

// File: src/ocm_pkg.sv
// Types shared by the two ends of the overhead channel message link.
// Assumes ocm_map.svh supplies the numeric constants.
package ocm_pkg;

  typedef enum logic [2:0] {
    OCM_IDLE = 3'b001,
    OCM_RUN  = 3'b010,
    OCM_GAP  = 3'b100
  } ocm_eng_t;

  // ----------------------------------------------------------------------------
  // Convergence end state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        tclk_m;
    logic        tclk_s;
    logic        tclk_p;
    logic        tdat_m;
    logic        tdat_s;
    logic        rclk_m;
    logic        rclk_s;
    logic        rclk_p;
    logic [15:0] tsh;
    logic [4:0]  tcnt;
    logic [15:0] tbuf;
    logic        tfull;
    logic        op_idle;
    logic [7:0]  oh_op;
    logic [15:0] oh_dat;
    logic        oh_vld;
    logic        lcm_ack;
    logic [15:0] rsh;
    logic [4:0]  rcnt;
    logic        rhold;
    logic        rop_idle;
    logic [7:0]  lrx_op;
    logic [15:0] lrx_dat;
    logic        lrx_vld;
  } ocm_dev_st_t;

  // ----------------------------------------------------------------------------
  // Processor end state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        perm_m;
    logic        perm_s;
    logic        rvld_m;
    logic        rvld_s;
    logic        rdat_m;
    logic        rdat_s;
    ocm_eng_t    teng;
    logic        tclk;
    logic [2:0]  tdiv;
    logic [4:0]  tcnt;
    logic [15:0] tsh;
    logic [3:0]  tgap;
    ocm_eng_t    reng;
    logic        rclk;
    logic [2:0]  rdiv;
    logic [4:0]  rcnt;
    logic [15:0] rsh;
    logic [3:0]  rgap;
    logic        ovld;
    logic [15:0] odat;
  } ocm_proc_st_t;

endpackage : ocm_pkg

// File: src/ocm_link_if.sv
// Message link between the convergence end and the message processor end.
// Assumes the bench connects one instance to both ends; no tri-state pins.
interface ocm_link_if;
  logic tx_clk;
  logic tx_data;
  logic tx_permit;
  logic rx_clk;
  logic rx_data;
  logic rx_valid;

  modport dev (
    input  tx_clk,
    input  tx_data,
    output tx_permit,
    input  rx_clk,
    output rx_data,
    output rx_valid
  );

  modport proc (
    output tx_clk,
    output tx_data,
    input  tx_permit,
    output rx_clk,
    input  rx_data,
    input  rx_valid
  );
endinterface : ocm_link_if

// File: src/ocm_conv.sv
// Overhead channel convergence end: multiplexes line-control messages and
// management messages into the per-codeword overhead field, and splits the
// received field back out.
// Assumes the codeword framer asks for one field per Slow codeword and hands
// over one received field per codeword; link pins are asynchronous.
`include "ocm_map.svh"

module ocm_conv (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  ocm_link_if.dev          link,
  input  wire logic        cw_tx_req_in,
  output logic             oh_tx_valid_out,
  output logic [7:0]       oh_tx_opcode_out,
  output logic [15:0]      oh_tx_data_out,
  input  wire logic        lcm_tx_valid_in,
  input  wire logic [7:0]  lcm_tx_opcode_in,
  input  wire logic [15:0] lcm_tx_data_in,
  output logic             lcm_tx_ready_out,
  input  wire logic        oh_rx_valid_in,
  input  wire logic [7:0]  oh_rx_opcode_in,
  input  wire logic [15:0] oh_rx_data_in,
  output logic             lcm_rx_valid_out,
  output logic [7:0]       lcm_rx_opcode_out,
  output logic [15:0]      lcm_rx_data_out
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic is_idle_op(input logic [7:0] op);
    is_idle_op = (op == `OCM_IDLE_OP);
  endfunction : is_idle_op

  ocm_pkg::ocm_dev_st_t q;
  ocm_pkg::ocm_dev_st_t d;

  logic lcm_go;
  logic tclk_rise;
  logic rclk_fall;

  // An opcode of 0xFF is no line-control message; such a request is taken and
  // dropped so that the requester cannot hang the overhead channel.
  assign lcm_go    = lcm_tx_valid_in & ~is_idle_op(lcm_tx_opcode_in);
  assign tclk_rise = q.tclk_s & ~q.tclk_p;
  assign rclk_fall = ~q.rclk_s & q.rclk_p;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    d = q;

    // Link pins cross in through two flops; only the second is looked at
    d.tclk_m = link.tx_clk;
    d.tclk_s = q.tclk_m;
    d.tclk_p = q.tclk_s;
    d.tdat_m = link.tx_data;
    d.tdat_s = q.tdat_m;
    d.rclk_m = link.rx_clk;
    d.rclk_s = q.rclk_m;
    d.rclk_p = q.rclk_s;

    d.oh_vld  = 1'b0;
    d.lcm_ack = 1'b0;
    d.lrx_vld = 1'b0;

    // --------------------------------------------------------------------------
    // Transmit: overhead field per codeword
    // --------------------------------------------------------------------------
    if (cw_tx_req_in) begin
      d.oh_vld = 1'b1;
      if (lcm_go) begin
        d.oh_op   = lcm_tx_opcode_in;
        d.oh_dat  = lcm_tx_data_in;
        d.op_idle = 1'b0;
        d.lcm_ack = 1'b1;
      end else begin
        d.oh_op   = `OCM_IDLE_OP;
        d.op_idle = 1'b1;
        d.lcm_ack = lcm_tx_valid_in;
        if (q.tfull) begin
          d.oh_dat = q.tbuf;
          d.tfull  = 1'b0;
        end else begin
          d.oh_dat = `OCM_NULL_DATA;
        end
      end
    end

    // --------------------------------------------------------------------------
    // Transmit: message in from the processor, sampled on tx_clk rise
    // --------------------------------------------------------------------------
    if (tclk_rise) begin
      d.tsh = {q.tsh[14:0], q.tdat_s};
      if (q.tcnt == `OCM_MSG_BITS - 5'h01) begin
        d.tcnt  = 5'h00;
        d.tbuf  = {q.tsh[14:0], q.tdat_s};
        d.tfull = 1'b1;
      end else begin
        d.tcnt = q.tcnt + 5'h01;
      end
    end

    // --------------------------------------------------------------------------
    // Receive: field from the codeword
    // --------------------------------------------------------------------------
    if (oh_rx_valid_in) begin
      if (is_idle_op(oh_rx_opcode_in)) begin
        // No receive buffer: a field not yet drained is overwritten
        d.rsh      = oh_rx_data_in;
        d.rcnt     = 5'h00;
        d.rhold    = 1'b1;
        d.rop_idle = 1'b1;
      end else begin
        d.lrx_vld  = 1'b1;
        d.lrx_op   = oh_rx_opcode_in;
        d.lrx_dat  = oh_rx_data_in;
        d.rop_idle = 1'b0;
      end
    end else if (rclk_fall && q.rhold) begin
      // Next bit is presented after each falling edge of rx_clk
      d.rsh = {q.rsh[14:0], 1'b0};
      if (q.rcnt == `OCM_MSG_BITS - 5'h01) begin
        d.rcnt  = 5'h00;
        d.rhold = 1'b0;
      end else begin
        d.rcnt = q.rcnt + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{
        tclk_m:   1'b0,
        tclk_s:   1'b0,
        tclk_p:   1'b0,
        tdat_m:   1'b0,
        tdat_s:   1'b0,
        rclk_m:   1'b0,
        rclk_s:   1'b0,
        rclk_p:   1'b0,
        tsh:      16'h0000,
        tcnt:     5'h00,
        tbuf:     16'h0000,
        tfull:    1'b0,
        op_idle:  1'b1,
        oh_op:    8'hFF,
        oh_dat:   16'h0000,
        oh_vld:   1'b0,
        lcm_ack:  1'b0,
        rsh:      16'h0000,
        rcnt:     5'h00,
        rhold:    1'b0,
        rop_idle: 1'b1,
        lrx_op:   8'h00,
        lrx_dat:  16'h0000,
        lrx_vld:  1'b0
      };
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Permit drops as soon as a line-control message waits, so no new message
  // starts while the opcode is about to leave idle.
  assign link.tx_permit = q.op_idle & ~lcm_tx_valid_in & ~q.tfull;
  assign link.rx_data   = q.rsh[15];
  assign link.rx_valid  = q.rhold & q.rop_idle;

  assign oh_tx_valid_out   = q.oh_vld;
  assign oh_tx_opcode_out  = q.oh_op;
  assign oh_tx_data_out    = q.oh_dat;
  assign lcm_tx_ready_out  = q.lcm_ack;
  assign lcm_rx_valid_out  = q.lrx_vld;
  assign lcm_rx_opcode_out = q.lrx_op;
  assign lcm_rx_data_out   = q.lrx_dat;

  // The same module serves both line ends, downstream and upstream alike.

endmodule : ocm_conv

// File: tb/ocm_link_asserts.sv
// Concurrent checks on the message link between the convergence end and the processor end.
// Assumes one instance beside the link interface, everything on mclk_in.
module ocm_link_asserts (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic tx_clk,
  input wire logic tx_data,
  input wire logic tx_permit,
  input wire logic rx_clk,
  input wire logic rx_data,
  input wire logic rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // Edge counters
  // ---------------------------------------------------------------------------
  // No framing signal, so bit position is counted from reset, modulo 16
  logic       tx_clk_q;
  logic       rx_clk_q;
  logic [3:0] tx_rise_q;
  logic [3:0] rx_rise_q;
  logic [3:0] rx_fall_q;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_clk_q  <= 1'b0;
      rx_clk_q  <= 1'b0;
      tx_rise_q <= 4'h0;
      rx_rise_q <= 4'h0;
      rx_fall_q <= 4'h0;
    end else begin
      tx_clk_q  <= tx_clk;
      rx_clk_q  <= rx_clk;
      tx_rise_q <= tx_rise_q + 4'(tx_clk & ~tx_clk_q);
      rx_rise_q <= rx_rise_q + 4'(rx_clk & ~rx_clk_q);
      rx_fall_q <= rx_fall_q + 4'(~rx_clk & rx_clk_q);
    end
  end

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_tx_clk_high: assert property ($rose(tx_clk) |-> tx_clk[*4] ##1 !tx_clk)
    else $error("tx_clk high phase is not four cycles");
  a_rx_clk_high: assert property ($rose(rx_clk) |-> rx_clk[*4] ##1 !rx_clk)
    else $error("rx_clk high phase is not four cycles");
  a_tx_clk_low: assert property ($fell(tx_clk) && tx_rise_q != 4'h0 |-> !tx_clk[*4] ##1 tx_clk)
    else $error("tx_clk low phase inside a message is not four cycles");
  a_tx_bit_hold: assert property ($rose(tx_clk) |-> $stable(tx_data)[*4])
    else $error("tx_data moved while tx_clk high");
  // Convergence end shifts a few cycles after the fall, so skip the rising cycle
  a_rx_bit_hold: assert property ($rose(rx_clk) |=> $stable(rx_data)[*3])
    else $error("rx_data moved while rx_clk high");
  a_permit_after_msg: assert property ($rose(tx_clk) && tx_rise_q == 4'hF |-> ##[1:6] !tx_permit)
    else $error("tx_permit stayed high after a full message");
  a_rx_valid_drain: assert property ($fell(rx_clk) && rx_fall_q == 4'hF |-> ##[1:6] !rx_valid)
    else $error("rx_valid stayed high after sixteen bits");
  a_rx_start_valid: assert property ($rose(rx_clk) && rx_rise_q == 4'h0 |-> rx_valid)
    else $error("rx_clk started without rx_valid");
  a_reset_link_idle: assert property ($fell(rst_in) |-> !tx_clk && !rx_clk && !rx_valid)
    else $error("link not idle after reset");
endmodule : ocm_link_asserts

// File: tb/tb.sv
// Self-checking bench: convergence end and processor end joined by one link.
// Assumes the design files and ocm_map.svh are compiled first.
`include "ocm_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  op;
    logic [15:0] dat;
    logic        to_msg;
  } ocm_row_t;

  logic        mclk_in;
  logic        rst_in;
  logic        cw_tx_req_in;
  logic        lcm_tx_valid_in;
  logic [7:0]  lcm_tx_opcode_in;
  logic [15:0] lcm_tx_data_in;
  logic        oh_rx_valid_in;
  logic [7:0]  oh_rx_opcode_in;
  logic [15:0] oh_rx_data_in;
  logic        msg_tx_valid_in;
  logic [15:0] msg_tx_data_in;
  logic        oh_tx_valid_out;
  logic [7:0]  oh_tx_opcode_out;
  logic [15:0] oh_tx_data_out;
  logic        lcm_tx_ready_out;
  logic        lcm_rx_valid_out;
  logic [7:0]  lcm_rx_opcode_out;
  logic [15:0] lcm_rx_data_out;
  logic        msg_tx_ready_out;
  logic        msg_rx_valid_out;
  logic [15:0] msg_rx_data_out;
  int          miscompares;
  int          checked;
  int          i;
  int          n;
  // Expected route: idle opcode goes up as a message, anything else to line control
  ocm_row_t    rows [6] = '{'{8'hFF, 16'hA5C3, 1'b1}, '{8'h12, 16'h3456, 1'b0}, '{8'hFF, 16'h8001, 1'b1},
                            '{8'h00, 16'hFFFF, 1'b0}, '{8'hFE, 16'h0F0F, 1'b0}, '{8'hFF, 16'h7FFE, 1'b1}};

  ocm_link_if u_ocm_link_if ();

  ocm_conv u_ocm_conv (
    .mclk_in (mclk_in), .rst_in (rst_in), .link (u_ocm_link_if),
    .cw_tx_req_in (cw_tx_req_in), .oh_tx_valid_out (oh_tx_valid_out),
    .oh_tx_opcode_out (oh_tx_opcode_out), .oh_tx_data_out (oh_tx_data_out),
    .lcm_tx_valid_in (lcm_tx_valid_in), .lcm_tx_opcode_in (lcm_tx_opcode_in),
    .lcm_tx_data_in (lcm_tx_data_in), .lcm_tx_ready_out (lcm_tx_ready_out),
    .oh_rx_valid_in (oh_rx_valid_in), .oh_rx_opcode_in (oh_rx_opcode_in), .oh_rx_data_in (oh_rx_data_in),
    .lcm_rx_valid_out (lcm_rx_valid_out), .lcm_rx_opcode_out (lcm_rx_opcode_out),
    .lcm_rx_data_out (lcm_rx_data_out));

  ocm_proc u_ocm_proc (
    .mclk_in (mclk_in), .rst_in (rst_in), .link (u_ocm_link_if),
    .msg_tx_valid_in (msg_tx_valid_in), .msg_tx_data_in (msg_tx_data_in),
    .msg_tx_ready_out (msg_tx_ready_out), .msg_rx_valid_out (msg_rx_valid_out),
    .msg_rx_data_out (msg_rx_data_out));

  ocm_link_asserts u_ocm_link_asserts (
    .mclk_in (mclk_in), .rst_in (rst_in), .tx_clk (u_ocm_link_if.tx_clk),
    .tx_data (u_ocm_link_if.tx_data), .tx_permit (u_ocm_link_if.tx_permit),
    .rx_clk (u_ocm_link_if.rx_clk), .rx_data (u_ocm_link_if.rx_data),
    .rx_valid (u_ocm_link_if.rx_valid));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_in);
  endtask : cyc

  // One codeword: optional line-control offer, then the field that goes out
  task automatic field(input logic lv, input logic [7:0] op, input logic [15:0] dat,
                       input logic [7:0] e_op, input logic [15:0] e_dat);
    lcm_tx_valid_in  = lv;
    lcm_tx_opcode_in = op;
    lcm_tx_data_in   = dat;
    cw_tx_req_in     = 1'b1;
    cyc(1);
    cw_tx_req_in     = 1'b0;
    lcm_tx_valid_in  = 1'b0;
    `CHK("oh_tx_valid_out", 1'b1, oh_tx_valid_out)
    `CHK("oh_tx_opcode_out", e_op, oh_tx_opcode_out)
    `CHK("oh_tx_data_out", e_dat, oh_tx_data_out)
    `CHK("lcm_tx_ready_out", lv, lcm_tx_ready_out)
    cyc(1);
  endtask : field

  task automatic wait_full;
    for (n = 0; n < 400 && u_ocm_link_if.tx_permit !== 1'b0; n++) cyc(1);
    `CHK("tx_permit full", 1'b0, u_ocm_link_if.tx_permit)
  endtask : wait_full

  task automatic check_idle;
    `CHK("idle opcode", 8'hFF, oh_tx_opcode_out)
    `CHK("idle data", 16'h0000, oh_tx_data_out)
    `CHK("tx_permit", 1'b1, u_ocm_link_if.tx_permit)
    `CHK("rx_valid", 1'b0, u_ocm_link_if.rx_valid)
    `CHK("link clocks", 2'b00, {u_ocm_link_if.tx_clk, u_ocm_link_if.rx_clk})
    `CHK("msg_tx_ready_out", 1'b1, msg_tx_ready_out)
  endtask : check_idle

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------------
  // Clock, watchdog and sequence
  // ---------------------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  // Longest stretch is the 32-message drain, near 5000 cycles; allow eight times that
  initial begin
    #2000000;
    miscompares++;
    final_report();
  end

  initial begin
    miscompares = 0;
    checked = 0;
    rst_in = 1'b1;
    {cw_tx_req_in, lcm_tx_valid_in, oh_rx_valid_in, msg_tx_valid_in} = 4'h0;
    {lcm_tx_opcode_in, oh_rx_opcode_in} = 16'h0000;
    {lcm_tx_data_in, oh_rx_data_in, msg_tx_data_in} = 48'h0;
    cyc(12);
    rst_in = 1'b0;
    cyc(1);
    check_idle();
    // Line-control rows go out as a field, idle rows as 0xFF/0x0000; each comes back in as a received field
    foreach (rows[r]) begin
      field(!rows[r].to_msg, rows[r].op, rows[r].dat, rows[r].to_msg ? 8'hFF : rows[r].op,
            rows[r].to_msg ? 16'h0000 : rows[r].dat);
      oh_rx_opcode_in = rows[r].op;
      oh_rx_data_in   = rows[r].dat;
      oh_rx_valid_in  = 1'b1;
      cyc(1);
      oh_rx_valid_in  = 1'b0;
      `CHK("lcm_rx_valid_out", !rows[r].to_msg, lcm_rx_valid_out)
      `CHK("rx_valid", rows[r].to_msg, u_ocm_link_if.rx_valid)
      if (rows[r].to_msg) begin
        for (n = 0; n < 400 && msg_rx_valid_out !== 1'b1; n++) cyc(1);
        `CHK("msg_rx_valid_out", 1'b1, msg_rx_valid_out)
        `CHK("msg_rx_data_out", rows[r].dat, msg_rx_data_out)
      end else begin
        `CHK("lcm_rx_opcode_out", rows[r].op, lcm_rx_opcode_out)
        `CHK("lcm_rx_data_out", rows[r].dat, lcm_rx_data_out)
      end
      cyc(20);
      `CHK("rx_valid drained", 1'b0, u_ocm_link_if.rx_valid)
    end
    // Buffered message and line-control offer meet at one codeword
    msg_tx_data_in  = 16'hC3A5;
    msg_tx_valid_in = 1'b1;
    cyc(1);
    msg_tx_valid_in = 1'b0;
    wait_full();
    field(1'b1, 8'h5A, 16'h1234, 8'h5A, 16'h1234);
    field(1'b0, 8'h00, 16'h0000, 8'hFF, 16'hC3A5);
    `CHK("tx_permit resumed", 1'b1, u_ocm_link_if.tx_permit)
    // Pending line-control offer holds the link, so the processor buffer fills
    lcm_tx_valid_in  = 1'b1;
    lcm_tx_opcode_in = 8'h33;
    lcm_tx_data_in   = 16'h5555;
    cyc(4);
    `CHK("tx_permit suspended", 1'b0, u_ocm_link_if.tx_permit)
    msg_tx_valid_in = 1'b1;
    for (i = 0; i < 40 && msg_tx_ready_out === 1'b1; i++) begin
      msg_tx_data_in = 16'hA000 + 16'(i);
      cyc(1);
    end
    msg_tx_valid_in = 1'b0;
    `CHK("fifo depth", `OCM_FIFO_DEPTH, i)
    `CHK("fifo refuses", 1'b0, msg_tx_ready_out)
    field(1'b1, 8'h33, 16'h5555, 8'h33, 16'h5555);
    // Opcode must go back to idle before the held messages can move
    field(1'b0, 8'h00, 16'h0000, 8'hFF, 16'h0000);
    for (i = 0; i < `OCM_FIFO_DEPTH; i++) begin
      wait_full();
      field(1'b0, 8'h00, 16'h0000, 8'hFF, 16'hA000 + 16'(i));
    end
    field(1'b0, 8'h00, 16'h0000, 8'hFF, 16'h0000);
    // Offer with the idle opcode is taken but the field stays idle
    field(1'b1, 8'hFF, 16'hBEEF, 8'hFF, 16'h0000);
    // Reset lands in the middle of a received message
    oh_rx_opcode_in = 8'hFF;
    oh_rx_data_in   = 16'h1111;
    oh_rx_valid_in  = 1'b1;
    cyc(1);
    oh_rx_valid_in  = 1'b0;
    cyc(30);
    rst_in = 1'b1;
    #1;
    `CHK("rx_valid async", 1'b0, u_ocm_link_if.rx_valid)
    cyc(3);
    rst_in = 1'b0;
    cyc(1);
    check_idle();
    final_report();
  end
endmodule : tb
